// ==== design/rws_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module rws_ctrl
  import rws_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CHIP_SELECT_LOW,
  input wire logic WRITE_STROBE_LOW,
  input wire logic READ_STROBE_LOW,
  input wire logic SPEED_STRAP,
  input wire logic CROSSOVER_AUTO_STRAP,
  input wire logic WAKE_ENABLE,
  input wire logic WAKE_POLARITY_HIGH,
  input wire logic WAKE_OPEN_DRAIN,
  input wire logic WAKE_EVENT,
  input wire logic WAKE_CLEAR,
  input wire logic SLEEP_REQ,
  output logic CORE_RESET_LOW,
  output logic WRITE_ACCEPT,
  output logic WRITES_ENABLED,
  output logic IN_SLEEP,
  output logic WAKE_INDICATOR_OUT_O,
  output logic WAKE_INDICATOR_OUT_OE,
  output logic DEFAULT_SPEED_100,
  output logic DEFAULT_FULL_DUPLEX,
  output logic DEFAULT_AUTONEG,
  output logic CROSSOVER_AUTO_EN
);
  ////////////////////////////////////////////////////////////////////////
  // Reset and straps
  logic rst_n;
  logic speed_w;
  logic xover_w;
  rws_por u_por (
    .clk(REF_CLK),
    .resetn(RESETN),
    .rst_n_out(rst_n)
  );
  rws_strap u_strap (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .speed_pin(SPEED_STRAP),
    .xover_pin(CROSSOVER_AUTO_STRAP),
    .speed_q(speed_w),
    .xover_q(xover_w)
  );
  ////////////////////////////////////////////////////////////////////////
  // Host access decode
  wire wr_cyc = !CHIP_SELECT_LOW && !WRITE_STROBE_LOW;
  wire rd_cyc = !CHIP_SELECT_LOW && !READ_STROBE_LOW;
  logic wr_dly_q;
  wire wr_edge = wr_cyc && !wr_dly_q;
  rws_acc_t acc_q;
  rws_acc_t acc_d;
  logic sleep_q;
  logic sleep_d;
  // Wake write is swallowed; the unlock read must follow it
  wire wake_wr = sleep_q && wr_edge;
  assign sleep_d = wake_wr ? 1'b0 : ((SLEEP_REQ && !sleep_q) ? 1'b1 : sleep_q);
  always_comb begin
    acc_d = acc_q;
    unique case (acc_q)
      RWS_POR: acc_d = RWS_LOCKED;
      RWS_LOCKED: if (rd_cyc && !sleep_q) acc_d = RWS_OPEN;
      RWS_OPEN: if (SLEEP_REQ || sleep_q) acc_d = RWS_LOCKED;
      default: acc_d = RWS_LOCKED;
    endcase
  end
  wire wr_ok = wr_edge && !sleep_q && (acc_q == RWS_OPEN);
  ////////////////////////////////////////////////////////////////////////
  // Wake indicator; latched event never clears sleep by itself
  logic pend_q;
  wire pend_d = (WAKE_ENABLE && WAKE_EVENT) ? 1'b1 :
    (WAKE_CLEAR || !WAKE_ENABLE) ? 1'b0 : pend_q;
  wire level_w = pend_q ~^ WAKE_POLARITY_HIGH;
  wire oe_w = WAKE_OPEN_DRAIN ? (level_w == 1'b0) : 1'b1;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_dly_q <= 1'b0;
      acc_q <= RWS_POR;
      sleep_q <= 1'b0;
      pend_q <= 1'b0;
      CORE_RESET_LOW <= 1'b0;
      WRITE_ACCEPT <= 1'b0;
      WRITES_ENABLED <= 1'b0;
      IN_SLEEP <= 1'b0;
      WAKE_INDICATOR_OUT_O <= 1'b0;
      WAKE_INDICATOR_OUT_OE <= 1'b0;
    end else begin
      wr_dly_q <= wr_cyc;
      acc_q <= acc_d;
      sleep_q <= sleep_d;
      pend_q <= pend_d;
      CORE_RESET_LOW <= 1'b1;
      WRITE_ACCEPT <= wr_ok;
      WRITES_ENABLED <= (acc_d == RWS_OPEN);
      IN_SLEEP <= sleep_d;
      WAKE_INDICATOR_OUT_O <= level_w;
      WAKE_INDICATOR_OUT_OE <= oe_w;
    end
  end
  // Defaults follow captured strap; duplex is always half
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DEFAULT_SPEED_100 <= SPEED_100M;
      DEFAULT_FULL_DUPLEX <= DUPLEX_HALF;
      DEFAULT_AUTONEG <= 1'b1;
      CROSSOVER_AUTO_EN <= XOVER_STRAP_RST;
    end else begin
      DEFAULT_SPEED_100 <= speed_w ? SPEED_100M : SPEED_10M;
      DEFAULT_FULL_DUPLEX <= DUPLEX_HALF;
      DEFAULT_AUTONEG <= speed_w;
      CROSSOVER_AUTO_EN <= xover_w;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_no_wr_locked;
    @(posedge REF_CLK) disable iff (!rst_n)
      (acc_q != RWS_OPEN) |=> !WRITE_ACCEPT;
  endproperty
  a_no_wr_locked: assert property (p_no_wr_locked)
    else $error("write accepted before unlock read");
  property p_wake_exit;
    @(posedge REF_CLK) disable iff (!rst_n)
      (sleep_q && wr_edge) |=> !sleep_q;
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("write did not wake device");
  property p_event_no_wake;
    @(posedge REF_CLK) disable iff (!rst_n)
      (sleep_q && !wr_edge) |=> sleep_q;
  endproperty
  a_event_no_wake: assert property (p_event_no_wake)
    else $error("left sleep without host write");
  property p_wake_assert;
    @(posedge REF_CLK) disable iff (!rst_n)
      (WAKE_ENABLE && WAKE_EVENT) |=> ##1 (WAKE_INDICATOR_OUT_O ==
        WAKE_POLARITY_HIGH);
  endproperty
  a_wake_assert: assert property (p_wake_assert)
    else $error("wake indicator not asserted");
  property p_od;
    @(posedge REF_CLK) disable iff (!rst_n)
      $past(WAKE_OPEN_DRAIN) |-> !(WAKE_INDICATOR_OUT_OE &&
        WAKE_INDICATOR_OUT_O);
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain output driven high");
  property p_strap_hold;
    @(posedge REF_CLK) disable iff (!rst_n)
      ($past(acc_q) != RWS_POR && acc_q != RWS_POR) |-> $stable(speed_w)
        && $stable(xover_w);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap changed after capture");
  property p_speed_map;
    @(posedge REF_CLK) disable iff (!rst_n)
      (acc_q != RWS_POR) |=> (DEFAULT_AUTONEG == DEFAULT_SPEED_100)
        && !DEFAULT_FULL_DUPLEX;
  endproperty
  a_speed_map: assert property (p_speed_map)
    else $error("default settings mismatch");
  property p_xover;
    @(posedge REF_CLK) disable iff (!rst_n)
      (acc_q != RWS_POR) |=> (CROSSOVER_AUTO_EN == $past(xover_w));
  endproperty
  a_xover: assert property (p_xover)
    else $error("crossover enable mismatch");
  property p_cs_qual;
    @(posedge REF_CLK) disable iff (!rst_n)
      CHIP_SELECT_LOW |=> !WRITE_ACCEPT;
  endproperty
  a_cs_qual: assert property (p_cs_qual)
    else $error("write without chip select");
  ////////////////////////////////////////////////////////////////////////
  // Lock, wake and strap corners; cheap to keep, hard to hit by hand
  property p_accept_pulse;
    @(posedge REF_CLK) disable iff (!rst_n)
      WRITE_ACCEPT |=> !WRITE_ACCEPT;
  endproperty
  a_accept_pulse: assert property (p_accept_pulse)
    else $error("write accept longer than one cycle");
  property p_accept_strobe;
    @(posedge REF_CLK) disable iff (!rst_n)
      $past(WRITE_STROBE_LOW) |-> !WRITE_ACCEPT;
  endproperty
  a_accept_strobe: assert property (p_accept_strobe)
    else $error("write accepted without write strobe");
  property p_read_unlock;
    @(posedge REF_CLK) disable iff (!rst_n)
      (acc_q == RWS_LOCKED && rd_cyc && !sleep_q) |=> WRITES_ENABLED;
  endproperty
  a_read_unlock: assert property (p_read_unlock)
    else $error("read did not unlock writes");
  property p_sleep_shut;
    @(posedge REF_CLK) disable iff (!rst_n)
      sleep_q |=> !WRITES_ENABLED;
  endproperty
  a_sleep_shut: assert property (p_sleep_shut)
    else $error("writes enabled while asleep");
  property p_no_open_in_sleep;
    @(posedge REF_CLK) disable iff (!rst_n)
      sleep_q |=> (acc_q != RWS_OPEN);
  endproperty
  a_no_open_in_sleep: assert property (p_no_open_in_sleep)
    else $error("access open while asleep");
  property p_wake_relock;
    @(posedge REF_CLK) disable iff (!rst_n)
      (sleep_q && wr_edge) |=> !WRITE_ACCEPT && !WRITES_ENABLED;
  endproperty
  a_wake_relock: assert property (p_wake_relock)
    else $error("wake write was carried out");
  property p_sleep_req_lock;
    @(posedge REF_CLK) disable iff (!rst_n)
      (SLEEP_REQ && acc_q == RWS_OPEN) |=> !WRITES_ENABLED;
  endproperty
  a_sleep_req_lock: assert property (p_sleep_req_lock)
    else $error("writes still enabled after sleep request");
  property p_accept_awake;
    @(posedge REF_CLK) disable iff (!rst_n)
      WRITE_ACCEPT |-> !$past(sleep_q);
  endproperty
  a_accept_awake: assert property (p_accept_awake)
    else $error("write accepted while asleep");
  property p_sleep_enter;
    @(posedge REF_CLK) disable iff (!rst_n)
      (SLEEP_REQ && !sleep_q) |=> IN_SLEEP;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("sleep request not taken");
  property p_evt_no_wake;
    @(posedge REF_CLK) disable iff (!rst_n)
      (sleep_q && WAKE_EVENT && !wr_edge) |=> sleep_q;
  endproperty
  a_evt_no_wake: assert property (p_evt_no_wake)
    else $error("wake event left sleep by itself");
  property p_ind_no_wake;
    @(posedge REF_CLK) disable iff (!rst_n)
      (sleep_q && pend_q && !wr_edge) |=> sleep_q;
  endproperty
  a_ind_no_wake: assert property (p_ind_no_wake)
    else $error("wake indicator left sleep by itself");
  property p_evt_latch;
    @(posedge REF_CLK) disable iff (!rst_n)
      (WAKE_ENABLE && WAKE_EVENT) |=> pend_q;
  endproperty
  a_evt_latch: assert property (p_evt_latch)
    else $error("wake event not latched");
  property p_clear;
    @(posedge REF_CLK) disable iff (!rst_n)
      (WAKE_CLEAR && !(WAKE_ENABLE && WAKE_EVENT)) |=> !pend_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("wake event not cleared");
  property p_pp_drive;
    @(posedge REF_CLK) disable iff (!rst_n)
      (CORE_RESET_LOW && !$past(WAKE_OPEN_DRAIN)) |-> WAKE_INDICATOR_OUT_OE;
  endproperty
  a_pp_drive: assert property (p_pp_drive)
    else $error("push-pull indicator not driven");
  property p_ind_idle;
    @(posedge REF_CLK) disable iff (!rst_n)
      !WAKE_ENABLE |=> ##1 (WAKE_INDICATOR_OUT_O !=
        $past(WAKE_POLARITY_HIGH));
  endproperty
  a_ind_idle: assert property (p_ind_idle)
    else $error("indicator asserted while disabled");
  property p_core_up;
    @(posedge REF_CLK) disable iff (!rst_n)
      !CORE_RESET_LOW |=> CORE_RESET_LOW;
  endproperty
  a_core_up: assert property (p_core_up)
    else $error("core reset held after internal release");
  property p_half_only;
    @(posedge REF_CLK) disable iff (!rst_n)
      !DEFAULT_FULL_DUPLEX;
  endproperty
  a_half_only: assert property (p_half_only)
    else $error("full duplex default selected");
  property p_speed_follow;
    @(posedge REF_CLK) disable iff (!rst_n)
      (acc_q != RWS_POR) |=> (DEFAULT_SPEED_100 == $past(speed_w));
  endproperty
  a_speed_follow: assert property (p_speed_follow)
    else $error("default speed does not follow strap");
  property p_autoneg_follow;
    @(posedge REF_CLK) disable iff (!rst_n)
      (acc_q != RWS_POR) |=> (DEFAULT_AUTONEG == $past(speed_w));
  endproperty
  a_autoneg_follow: assert property (p_autoneg_follow)
    else $error("default negotiation does not follow strap");
  c_sleep_evt: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    sleep_q && pend_q);
  c_od_drive: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    WAKE_OPEN_DRAIN && WAKE_INDICATOR_OUT_OE);
  c_unlock: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    acc_q == RWS_LOCKED ##1 acc_q == RWS_OPEN);
  c_wake: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    sleep_q ##1 !sleep_q);
  c_write: cover property (@(posedge REF_CLK) disable iff (!rst_n)
    WRITE_ACCEPT);
endmodule : rws_ctrl
`default_nettype wire

// ==== design/rws_por.sv ====
`timescale 1ns/10ps
`default_nettype none
module rws_por
  import rws_pkg::*;
#(
  parameter int unsigned CYCLES = POR_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  output logic rst_n_out
);
  logic [POR_CNT_W-1:0] cnt_q;
  logic [POR_CNT_W-1:0] cnt_d;
  logic done_w;
  // Internal reset holds until the count expires
  assign done_w = (cnt_q >= POR_CNT_W'(CYCLES));
  assign cnt_d = done_w ? cnt_q : cnt_q + POR_CNT_W'(1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      rst_n_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rst_n_out <= done_w;
    end
  end
endmodule : rws_por
`default_nettype wire

// ==== design/rws_strap.sv ====
`timescale 1ns/10ps
`default_nettype none
module rws_strap
  import rws_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic speed_pin,
  input wire logic xover_pin,
  output logic speed_q,
  output logic xover_q
);
  logic taken_q;
  // Capture on first clock after release, never again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_q <= 1'b0;
      speed_q <= SPEED_STRAP_RST;
      xover_q <= XOVER_STRAP_RST;
    end else if (!taken_q) begin
      taken_q <= 1'b1;
      speed_q <= speed_pin;
      xover_q <= xover_pin;
    end
  end
endmodule : rws_strap
`default_nettype wire

// ==== include/rws_pkg.sv ====
package rws_pkg;
  localparam int unsigned REF_CLK_HZ = 25_000_000;
  localparam int unsigned POR_TIME_NS = 1000;
  localparam int unsigned POR_CYCLES =
    (POR_TIME_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned POR_CNT_W = 6;
  localparam logic SPEED_STRAP_RST = 1'b1;
  localparam logic XOVER_STRAP_RST = 1'b0;
  localparam logic SPEED_10M = 1'b0;
  localparam logic SPEED_100M = 1'b1;
  localparam logic DUPLEX_HALF = 1'b0;
  typedef enum logic [1:0] {RWS_POR, RWS_LOCKED, RWS_OPEN} rws_acc_t;
endpackage : rws_pkg

// ==== tb/rws_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rws_host_model (
  input wire logic clk,
  output logic cs_low,
  output logic wr_low,
  output logic rd_low
);
  initial begin
    cs_low = 1'b1;
    wr_low = 1'b1;
    rd_low = 1'b1;
  end
  // Strobes drop back high between accesses so each write is a new edge
  task automatic access(input logic is_write);
    @(posedge clk);
    cs_low <= 1'b0;
    if (is_write) wr_low <= 1'b0;
    else rd_low <= 1'b0;
    repeat (2) @(posedge clk);
    cs_low <= 1'b1;
    wr_low <= 1'b1;
    rd_low <= 1'b1;
    @(posedge clk);
  endtask : access
  task read_cycle;
    access(1'b0);
  endtask : read_cycle
  // No address or data lines here; a write is a chip select and write strobe pulse
  task write_cycle;
    access(1'b1);
  endtask : write_cycle
endmodule : rws_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic reset_low = 1'b0;
  logic speed = 1'b0, xover = 1'b1, wen = 1'b0, wpol = 1'b0, wod = 1'b0;
  logic wev = 1'b0, wclr = 1'b0, sleep = 1'b0;
  logic cs_low, wr_low, rd_low, core_low, wr_acc, wr_en, in_sleep;
  logic wk_o, wk_oe, spd100, fdx, aneg, xen;
  logic [7:0] accepts = 8'h00;
  int mismatches = 0;
  int checks = 0;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wr_acc === 1'b1) accepts <= accepts + 8'h01;
  rws_host_model host_u (.clk(ref_clk), .cs_low(cs_low), .wr_low(wr_low),
    .rd_low(rd_low));
  rws_ctrl dut_u (.REF_CLK(ref_clk), .RESETN(reset_low),
    .CHIP_SELECT_LOW(cs_low), .WRITE_STROBE_LOW(wr_low),
    .READ_STROBE_LOW(rd_low), .SPEED_STRAP(speed),
    .CROSSOVER_AUTO_STRAP(xover), .WAKE_ENABLE(wen),
    .WAKE_POLARITY_HIGH(wpol), .WAKE_OPEN_DRAIN(wod), .WAKE_EVENT(wev),
    .WAKE_CLEAR(wclr), .SLEEP_REQ(sleep), .CORE_RESET_LOW(core_low),
    .WRITE_ACCEPT(wr_acc), .WRITES_ENABLED(wr_en), .IN_SLEEP(in_sleep),
    .WAKE_INDICATOR_OUT_O(wk_o), .WAKE_INDICATOR_OUT_OE(wk_oe),
    .DEFAULT_SPEED_100(spd100), .DEFAULT_FULL_DUPLEX(fdx),
    .DEFAULT_AUTONEG(aneg), .CROSSOVER_AUTO_EN(xen));
  ////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  task pulse_event;
    @(posedge ref_clk);
    wev <= 1'b1;
    @(posedge ref_clk);
    wev <= 1'b0;
    settle;
  endtask : pulse_event
  task reset_dut(input logic s, input logic x);
    int i;
    @(posedge ref_clk);
    reset_low <= 1'b0;
    speed <= s;
    xover <= x;
    repeat (11) @(posedge ref_clk);
    #1;
    chk("core_reset", core_low, 1'b0);
    chk("writes_en_rst", wr_en, 1'b0);
    chk("sleep_rst", in_sleep, 1'b0);
    chk("speed_rst", spd100, 1'b1);
    @(posedge ref_clk);
    reset_low <= 1'b1;
    // Internal power-on hold runs alone after the pin lets go
    for (i = 0; i < 100 && core_low !== 1'b1; i++) @(posedge ref_clk);
    chk("core_release", core_low, 1'b1);
    repeat (3) @(posedge ref_clk);
    speed <= ~s;
    xover <= ~x;
    settle;
  endtask : reset_dut
  initial begin
    reset_dut(1'b0, 1'b1);
    chk("speed_100", spd100, 1'b0);
    chk("autoneg", aneg, 1'b0);
    chk("full_duplex", fdx, 1'b0);
    chk("crossover", xen, 1'b1);
    host_u.write_cycle();
    settle;
    chk("early_write", accepts, 8'h00);
    host_u.read_cycle();
    settle;
    chk("writes_en", wr_en, 1'b1);
    host_u.write_cycle();
    host_u.write_cycle();
    settle;
    chk("accepts_two", accepts, 8'h02);
    @(posedge ref_clk);
    wen <= 1'b1;
    wpol <= 1'b1;
    sleep <= 1'b1;
    @(posedge ref_clk);
    sleep <= 1'b0;
    settle;
    chk("in_sleep", in_sleep, 1'b1);
    pulse_event;
    chk("ind_high", wk_o, 1'b1);
    chk("ind_pp_oe", wk_oe, 1'b1);
    chk("still_sleep", in_sleep, 1'b1);
    @(posedge ref_clk);
    wclr <= 1'b1;
    wod <= 1'b1;
    wpol <= 1'b0;
    @(posedge ref_clk);
    wclr <= 1'b0;
    settle;
    chk("od_release", wk_oe, 1'b0);
    pulse_event;
    chk("ind_low", wk_o, 1'b0);
    chk("ind_od_oe", wk_oe, 1'b1);
    @(posedge ref_clk);
    wen <= 1'b0;
    pulse_event;
    chk("ind_disabled", wk_oe, 1'b0);
    host_u.write_cycle();
    settle;
    chk("woke", in_sleep, 1'b0);
    chk("wake_consumed", accepts, 8'h02);
    chk("relocked", wr_en, 1'b0);
    host_u.read_cycle();
    host_u.write_cycle();
    settle;
    chk("accepts_three", accepts, 8'h03);
    reset_dut(1'b1, 1'b0);
    chk("speed_100b", spd100, 1'b1);
    chk("autoneg_b", aneg, 1'b1);
    chk("crossover_b", xen, 1'b0);
    chk("writes_en_b", wr_en, 1'b0);
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
